// ==== verilog/flash_ctrl_regs.svh ====
// Register map, field positions, reset values and timing figures
// Assumes inclusion by name from the top module
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH

// Serial slave address (7 bits)
`define SLAVE_ADDR        7'h53

// Register byte addresses
`define ADDR_MODE         8'h10
`define ADDR_LEVEL        8'ha0
`define ADDR_OPTION       8'hb0
`define ADDR_SENSE_HI     8'hc0
`define ADDR_SENSE_LO     8'hd0

// Power-on values
`define RST_MODE          8'h00
`define RST_LEVEL         8'hf8
`define RST_OPTION        8'h80
`define RST_SENSE_HI      8'hf9
`define RST_SENSE_LO      8'hc6

// mode_control fields
`define MODE_IND          7
`define MODE_SENSE        6
`define MODE_GATE         5
`define MODE_CT_HI        4
`define MODE_CT_LO        3
`define MODE_FLASH        2
`define MODE_CHARGE       1
`define MODE_TORCH        0

// led_level_control fields
`define LEVEL_FLASH_HI    5
`define LEVEL_FLASH_LO    3
`define LEVEL_TORCH_HI    2
`define LEVEL_TORCH_LO    0

// option_settings fields
`define OPT_SENS          7
`define OPT_TO_HI         6
`define OPT_TO_LO         3
`define OPT_OH_HI         2
`define OPT_OH_LO         0

// Charge target code for optimal charging
`define CT_OPTIMAL        2'h0

// Flash timeout: one step is 16 ms, code 15 means 32 steps
`define FLASH_STEP_US     16000
`define CLK_MHZ           50
`define TO_LONG_CODE      4'hf
`define TO_LONG_STEPS     6'h20

// Serial bit counter marks
`define BIT_LAST          4'h7
`define BIT_ACK           4'h8
// One below bit 0, so the SCL fall that closes a START lands on bit 0
`define BIT_START         4'hf

// Register index codes
`define IDX_MODE          3'h0
`define IDX_LEVEL         3'h1
`define IDX_OPTION        3'h2
`define IDX_SENSE_HI      3'h3
`define IDX_SENSE_LO      3'h4
`define IDX_NONE          3'h7

`endif

// ==== verilog/flash_ctrl_pkg.sv ====
// Types shared by the flash driver control logic
// Assumes the register header supplies all numeric constants
package flash_ctrl_pkg;

  // Operating states of the driver
  typedef enum logic [2:0] {
    st_off, st_torch, st_charge, st_charge_torch, st_flash
  } mode_state_e;

  // Phases of the serial slave
  typedef enum logic [2:0] {
    lp_idle, lp_addr, lp_reg, lp_data, lp_read
  } link_phase_e;

  // One register write handed from the link to the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_word_s;

  // Controls towards the analog section
  typedef struct packed {
    logic       active;
    logic       torch_en;
    logic       charge_en;
    logic       flash_en;
    logic       indicator_en;
    logic       sense_en;
    logic [1:0] charge_target;
    logic [2:0] torch_level;
    logic [2:0] flash_level;
    logic [2:0] overhead;
    logic [7:0] sense_hi;
    logic [7:0] sense_lo;
  } drive_s;

endpackage

// ==== verilog/flash_driver_mode_control.sv ====
// Mode control and serial register bank of a flash LED driver
// Assumes SCL/SDA, strobe and cap comparator arrive asynchronously;
// link_clk is a free-running oversampling clock for the serial slave
`timescale 1ns/1ns
`include "flash_ctrl_regs.svh"

// Contract
// - Flash starts from software flash bit or strobe pin, edge or level.
// - Flash level from level register, duration from option register.
// - With gate bit 0, flash waits until end-of-charge goes low.
// - Software-started flash clears flash and torch bits on completion.
// - After flash resume prior charge mode; optimal mode stops charging.
// - End-of-charge low when capacitor reaches its target.
// - End-of-charge tracked continuously, re-evaluated on mode change.
// - Torch-only mode holds end-of-charge high.
// - Gate bit 1 allows flash at any time.
// - SDA changes only while SCL is low.
// - Repeated START acts as START; STOP frees the bus.
// - Bytes are eight bits, MSB first, then an acknowledge slot.
// - Slave pulls SDA low in the ninth clock after each byte; after a read data byte the code releases SDA for the master.
// - First byte is address 53h plus direction bit.
// - Write: register byte, then data byte stored there.
// - Mode register at 0x10 holds the documented bit layout.
// - Flash bit wins; else charge,torch decode the mode.
// - Charge target codes: optimal, 4.5 V, 5.0 V, 5.3 V.
// - Indicator enable bit switches the indicator source.
// - Trigger sensitivity 0 edge, 1 level.
// - Timeout 16 ms times code plus one; code 15 gives 512 ms.
// - Flash level codes select 30 mV to 100 mV feedback.
// - Power-up in shutdown; stays while no request is present.
module flash_driver_mode_control
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `FLASH_STEP_US * `CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic link_clk,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic strobe_in,
  input  wire logic cap_at_target_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  output logic      eoc_n,
  output drive_s    drive
);

  // Map a register address to an index, unmapped gives none
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    unique case (a)
      `ADDR_MODE:     reg_sel = `IDX_MODE;
      `ADDR_LEVEL:    reg_sel = `IDX_LEVEL;
      `ADDR_OPTION:   reg_sel = `IDX_OPTION;
      `ADDR_SENSE_HI: reg_sel = `IDX_SENSE_HI;
      `ADDR_SENSE_LO: reg_sel = `IDX_SENSE_LO;
      default:        reg_sel = `IDX_NONE;
    endcase
  endfunction

  // Non-flash state from the charge and torch bits
  function automatic mode_state_e base_state(input logic [7:0] m);
    unique case ({m[`MODE_CHARGE], m[`MODE_TORCH]})
      2'b00:   base_state = st_off;
      2'b01:   base_state = st_torch;
      2'b10:   base_state = st_charge;
      default: base_state = st_charge_torch;
    endcase
  endfunction

  // Link domain: synchronisers and edge history
  logic        scl_m_q, scl_s_q, scl_p_q;
  logic        sda_m_q, sda_s_q, sda_p_q;
  logic        ack_m_q, ack_s_q, ack_p_q;
  // Link domain: slave state
  link_phase_e ph_q, ph_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  rx_q, rx_d;
  logic [7:0]  tx_q, tx_d;
  logic [7:0]  ptr_q, ptr_d;
  logic [7:0]  rd_buf_q, rd_buf_d;
  logic        oe_n_q, oe_n_d;
  logic        mack_q, mack_d;
  logic        wr_tog_q, wr_tog_d;
  logic        rd_req_q, rd_req_d;
  wr_word_s    wr_q, wr_d;
  logic        sda_out_q;
  logic        start_c, stop_c, rise_c, fall_c;

  // Core domain: synchronisers
  logic        stb_m_q, stb_s_q, stb_p_q;
  logic        cap_m_q, cap_s_q;
  logic        wt_m_q, wt_s_q, wt_p_q;
  logic        rq_m_q, rq_s_q, rq_p_q;
  // Core domain: registers and sequencing
  logic [7:0]  mode_q, mode_d;
  logic [7:0]  level_q, level_d;
  logic [7:0]  opt_q, opt_d;
  logic [7:0]  shi_q, shi_d;
  logic [7:0]  slo_q, slo_d;
  mode_state_e st_q, st_d;
  logic        src_sw_q, src_sw_d;
  logic        pend_q, pend_d;
  logic        armed_q, armed_d;
  logic [23:0] step_cnt_q, step_cnt_d;
  logic [5:0]  step_num_q, step_num_d;
  logic        eoc_n_q, eoc_n_d;
  logic [7:0]  rd_data_q, rd_data_d;
  logic        rd_ack_q, rd_ack_d;
  drive_s      drive_q, drive_d;

  // Serial pin sampling; a third stage gives edge history
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      ack_p_q <= 1'b0;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      ack_m_q <= rd_ack_q;
      ack_s_q <= ack_m_q;
      ack_p_q <= ack_s_q;
    end
  end

  // Bus conditions seen on the synchronised lines
  // start and stop, then SCL rise and fall
  assign start_c = scl_s_q & sda_p_q & ~sda_s_q;
  assign stop_c  = scl_s_q & ~sda_p_q & sda_s_q;
  assign rise_c  = scl_s_q & ~scl_p_q;
  assign fall_c  = ~scl_s_q & scl_p_q;

  // Serial slave next state; SDA changes after SCL falls, and is also released at START and STOP
  always_comb begin
    ph_d     = ph_q;
    cnt_d    = cnt_q;
    rx_d     = rx_q;
    tx_d     = tx_q;
    ptr_d    = ptr_q;
    oe_n_d   = oe_n_q;
    mack_d   = mack_q;
    wr_tog_d = wr_tog_q;
    rd_req_d = rd_req_q;
    wr_d     = wr_q;
    // Read data is stable once the core's answer toggle arrives
    rd_buf_d = (ack_s_q != ack_p_q) ? rd_data_q : rd_buf_q;
    if (start_c) begin
      ph_d   = lp_addr;
      // The SCL fall closing START must not count as a data bit
      cnt_d  = `BIT_START;
      oe_n_d = 1'b1;
    end else if (stop_c) begin
      ph_d   = lp_idle;
      oe_n_d = 1'b1;
    end else if (ph_q != lp_idle) begin
      if (rise_c) begin
        if (cnt_q <= `BIT_LAST) rx_d = {rx_q[6:0], sda_s_q};
        else mack_d = sda_s_q;
      end
      if (fall_c) begin
        if (cnt_q == `BIT_LAST) begin
          cnt_d = `BIT_ACK;
          unique case (ph_q)
            lp_addr: begin
              if (rx_q[7:1] == `SLAVE_ADDR) begin
                oe_n_d = 1'b0;
                if (rx_q[0]) rd_req_d = ~rd_req_q;
              end else begin
                ph_d = lp_idle;
              end
            end
            lp_reg: begin
              oe_n_d = 1'b0;
              ptr_d  = rx_q;
            end
            lp_data: begin
              oe_n_d   = 1'b0;
              wr_d     = '{addr: ptr_q, data: rx_q};
              wr_tog_d = ~wr_tog_q;
            end
            default: oe_n_d = 1'b1;
          endcase
        end else if (cnt_q == `BIT_ACK) begin
          cnt_d  = 4'h0;
          oe_n_d = 1'b1;
          unique case (ph_q)
            lp_addr: begin
              if (rx_q[0]) begin
                ph_d   = lp_read;
                oe_n_d = rd_buf_q[7];
                tx_d   = {rd_buf_q[6:0], 1'b0};
              end else begin
                ph_d = lp_reg;
              end
            end
            lp_reg:  ph_d = lp_data;
            lp_read: begin
              // Master not acking ends the read
              if (mack_q) begin
                ph_d = lp_idle;
              end else begin
                oe_n_d = rd_buf_q[7];
                tx_d   = {rd_buf_q[6:0], 1'b0};
              end
            end
            default: ph_d = ph_q;
          endcase
        end else begin
          cnt_d = cnt_q + 4'h1;
          if (ph_q == lp_read) begin
            oe_n_d = tx_q[7];
            tx_d   = {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Serial slave registers
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      ph_q      <= lp_idle;
      cnt_q     <= 4'h0;
      rx_q      <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rd_buf_q  <= 8'h00;
      oe_n_q    <= 1'b1;
      mack_q    <= 1'b1;
      wr_tog_q  <= 1'b0;
      rd_req_q  <= 1'b0;
      wr_q      <= '0;
      sda_out_q <= 1'b0;
    end else begin
      ph_q      <= ph_d;
      cnt_q     <= cnt_d;
      rx_q      <= rx_d;
      tx_q      <= tx_d;
      ptr_q     <= ptr_d;
      rd_buf_q  <= rd_buf_d;
      oe_n_q    <= oe_n_d;
      mack_q    <= mack_d;
      wr_tog_q  <= wr_tog_d;
      rd_req_q  <= rd_req_d;
      wr_q      <= wr_d;
      sda_out_q <= 1'b0;
    end
  end

  // Core-side synchronisers for pins and link toggles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stb_m_q <= 1'b0;
      stb_s_q <= 1'b0;
      stb_p_q <= 1'b0;
      cap_m_q <= 1'b0;
      cap_s_q <= 1'b0;
      wt_m_q  <= 1'b0;
      wt_s_q  <= 1'b0;
      wt_p_q  <= 1'b0;
      rq_m_q  <= 1'b0;
      rq_s_q  <= 1'b0;
      rq_p_q  <= 1'b0;
    end else begin
      stb_m_q <= strobe_in;
      stb_s_q <= stb_m_q;
      stb_p_q <= stb_s_q;
      cap_m_q <= cap_at_target_in;
      cap_s_q <= cap_m_q;
      wt_m_q  <= wr_tog_q;
      wt_s_q  <= wt_m_q;
      wt_p_q  <= wt_s_q;
      rq_m_q  <= rd_req_q;
      rq_s_q  <= rq_m_q;
      rq_p_q  <= rq_s_q;
    end
  end

  // Register bank and flash sequencing
  always_comb begin
    logic       level_mode;
    logic       strobe_req;
    logic       mode_wr;
    logic       last_tick;
    logic       done;
    logic [5:0] steps_needed;
    logic [3:0] to_code;
    level_mode   = 1'b0;
    strobe_req   = 1'b0;
    last_tick    = 1'b0;
    steps_needed = 6'h00;
    to_code      = 4'h0;
    mode_d     = mode_q;
    level_d    = level_q;
    opt_d      = opt_q;
    shi_d      = shi_q;
    slo_d      = slo_q;
    st_d       = st_q;
    src_sw_d   = src_sw_q;
    pend_d     = pend_q;
    armed_d    = armed_q;
    step_cnt_d = step_cnt_q;
    step_num_d = step_num_q;
    rd_data_d  = rd_data_q;
    rd_ack_d   = rd_ack_q;
    mode_wr    = 1'b0;
    done       = 1'b0;
    level_mode = opt_q[`OPT_SENS];
    if (stb_s_q & ~stb_p_q) pend_d = 1'b1;
    if (~stb_s_q) armed_d = 1'b1;
    strobe_req = level_mode ? (stb_s_q & armed_q) : pend_q;
    to_code      = opt_q[`OPT_TO_HI:`OPT_TO_LO];
    steps_needed = (to_code == `TO_LONG_CODE) ? `TO_LONG_STEPS
                                              : {2'b00, to_code} + 6'h01;
    last_tick    = step_cnt_q == 24'(STEP_CYCLES - 1);
    unique case (st_q)
      st_flash: begin
        if (last_tick) begin
          step_cnt_d = 24'h000000;
          step_num_d = step_num_q + 6'h01;
        end else begin
          step_cnt_d = step_cnt_q + 24'h000001;
        end
        done = (last_tick && (step_num_q + 6'h01 == steps_needed))
             | (~src_sw_q & level_mode & ~stb_s_q);
        if (done) begin
          if (src_sw_q) begin
            mode_d[`MODE_FLASH] = 1'b0;
            mode_d[`MODE_TORCH] = 1'b0;
          end
          if (mode_q[`MODE_CT_HI:`MODE_CT_LO] == `CT_OPTIMAL)
            mode_d[`MODE_CHARGE] = 1'b0;
          pend_d = 1'b0;
        end
      end
      default: begin
        // flash request, wait for charge, gate
        if ((mode_q[`MODE_FLASH] | strobe_req) &
            (mode_q[`MODE_GATE] | ~eoc_n_q)) begin
          st_d       = st_flash;
          src_sw_d   = mode_q[`MODE_FLASH];
          step_cnt_d = 24'h000000;
          step_num_d = 6'h00;
          pend_d     = 1'b0;
          armed_d    = 1'b0;
        end
      end
    endcase
    // Writes land after the self clear so software wins that cycle
    // unmapped ignored
    if (wt_s_q != wt_p_q) begin
      unique case (reg_sel(wr_q.addr))
        `IDX_MODE: begin
          mode_d  = wr_q.data;
          mode_wr = 1'b1;
        end
        `IDX_LEVEL:    level_d = wr_q.data;
        `IDX_OPTION:   opt_d   = wr_q.data;
        `IDX_SENSE_HI: shi_d   = wr_q.data;
        `IDX_SENSE_LO: slo_d   = wr_q.data;
        default:       mode_wr = 1'b0;
      endcase
    end
    if (st_q != st_flash || done) st_d = (st_d == st_flash && !done)
                                         ? st_flash : base_state(mode_d);
    eoc_n_d = ((st_d == st_charge || st_d == st_charge_torch) && !mode_wr)
              ? ~cap_s_q : 1'b1;
    // Read answer for the link; held until the next request
    if (rq_s_q != rq_p_q) begin
      unique case (reg_sel(ptr_q))
        `IDX_MODE:     rd_data_d = mode_q;
        `IDX_LEVEL:    rd_data_d = level_q;
        `IDX_OPTION:   rd_data_d = opt_q;
        `IDX_SENSE_HI: rd_data_d = shi_q;
        `IDX_SENSE_LO: rd_data_d = slo_q;
        default:       rd_data_d = 8'h00;
      endcase
      rd_ack_d = ~rd_ack_q;
    end
    // Analog controls
    drive_d.active        = st_d != st_off;
    drive_d.torch_en      = st_d == st_torch || st_d == st_charge_torch;
    drive_d.charge_en     = st_d == st_charge || st_d == st_charge_torch;
    drive_d.flash_en      = st_d == st_flash;
    drive_d.indicator_en  = mode_d[`MODE_IND];
    drive_d.sense_en      = mode_d[`MODE_SENSE];
    drive_d.charge_target = mode_d[`MODE_CT_HI:`MODE_CT_LO];
    drive_d.torch_level   = level_d[`LEVEL_TORCH_HI:`LEVEL_TORCH_LO];
    drive_d.flash_level   = level_d[`LEVEL_FLASH_HI:`LEVEL_FLASH_LO];
    drive_d.overhead      = opt_d[`OPT_OH_HI:`OPT_OH_LO];
    drive_d.sense_hi      = shi_d;
    drive_d.sense_lo      = slo_d;
  end

  // Core registers; power-on values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q     <= `RST_MODE;
      level_q    <= `RST_LEVEL;
      opt_q      <= `RST_OPTION;
      shi_q      <= `RST_SENSE_HI;
      slo_q      <= `RST_SENSE_LO;
      st_q       <= st_off;
      src_sw_q   <= 1'b0;
      pend_q     <= 1'b0;
      armed_q    <= 1'b0;
      step_cnt_q <= 24'h000000;
      step_num_q <= 6'h00;
      eoc_n_q    <= 1'b1;
      rd_data_q  <= 8'h00;
      rd_ack_q   <= 1'b0;
      drive_q    <= '0;
    end else begin
      mode_q     <= mode_d;
      level_q    <= level_d;
      opt_q      <= opt_d;
      shi_q      <= shi_d;
      slo_q      <= slo_d;
      st_q       <= st_d;
      src_sw_q   <= src_sw_d;
      pend_q     <= pend_d;
      armed_q    <= armed_d;
      step_cnt_q <= step_cnt_d;
      step_num_q <= step_num_d;
      eoc_n_q    <= eoc_n_d;
      rd_data_q  <= rd_data_d;
      rd_ack_q   <= rd_ack_d;
      drive_q    <= drive_d;
    end
  end

  // Outputs straight from flops
  assign sda_out  = sda_out_q;
  assign sda_oe_n = oe_n_q;
  assign eoc_n    = eoc_n_q;
  assign drive    = drive_q;

endmodule // flash_driver_mode_control

// ==== test/flash_driver_mode_control_asserts.sv ====
// Concurrent checks on the ports of the flash driver mode control block
// Assumes binding into the design top; STEP_CYCLES follows the design
`timescale 1ns/1ns
module flash_driver_mode_control_asserts
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 20
) (
  input wire logic   clk,
  input wire logic   rst,
  input wire logic   link_clk,
  input wire logic   scl_in,
  input wire logic   strobe_in,
  input wire logic   cap_at_target_in,
  input wire logic   sda_out,
  input wire logic   sda_oe_n,
  input wire logic   eoc_n,
  input wire drive_s drive
);
  logic [31:0] len_q;
  logic [31:0] len_d;

  // Flash length counter, cleared whenever the flash drive is off
  always_comb len_d = drive.flash_en ? len_q + 32'h1 : 32'h0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) len_q <= 32'h0;
    else len_q <= len_d;
  end

  AST_SDA_OUT_LOW: assert property (
    @(posedge link_clk) disable iff (rst)
    sda_out == 1'b0) else $error("sda_out not low");
  AST_SDA_SCL_LOW: assert property (
    @(posedge link_clk) disable iff (rst)
    $changed(sda_oe_n) |-> !scl_in) else $error("SDA moved with SCL high");
  AST_EOC_NO_CHARGE: assert property (
    @(posedge clk) disable iff (rst)
    !drive.charge_en [*3] |-> eoc_n) else $error("eoc low without charge");
  AST_EOC_NEEDS_CAP: assert property (
    @(posedge clk) disable iff (rst)
    $fell(eoc_n) |-> $past(cap_at_target_in, 2))
    else $error("eoc fell without target");
  AST_EOC_IN_FLASH: assert property (
    @(posedge clk) disable iff (rst)
    drive.flash_en [*2] |-> eoc_n) else $error("eoc low during flash");
  AST_FLASH_MAX: assert property (
    @(posedge clk) disable iff (rst)
    len_q <= 32 * STEP_CYCLES) else $error("flash beyond longest timeout");
  AST_FLASH_STEP_END: assert property (
    @(posedge clk) disable iff (rst)
    (!strobe_in [*8] ##1 $fell(drive.flash_en)) |->
      (len_q % STEP_CYCLES) == 0) else $error("flash ended off a step");
  AST_FLASH_MIN: assert property (
    @(posedge clk) disable iff (rst)
    $rose(drive.flash_en) && !strobe_in |-> drive.flash_en [*8])
    else $error("flash cut short");
  AST_FLASH_ACTIVE: assert property (
    @(posedge clk) disable iff (rst)
    drive.flash_en |-> drive.active) else $error("flash while shut down");

  // Main scenarios reached
  cover property (@(posedge clk) $rose(drive.flash_en) && !strobe_in);
  cover property (@(posedge clk) $rose(drive.flash_en) && strobe_in);
  cover property (@(posedge clk) $fell(eoc_n));
endmodule // flash_driver_mode_control_asserts

bind flash_driver_mode_control flash_driver_mode_control_asserts #(
  .STEP_CYCLES(STEP_CYCLES)
) u_asserts (
  .clk              (clk),
  .rst              (rst),
  .link_clk         (link_clk),
  .scl_in           (scl_in),
  .strobe_in        (strobe_in),
  .cap_at_target_in (cap_at_target_in),
  .sda_out          (sda_out),
  .sda_oe_n         (sda_oe_n),
  .eoc_n            (eoc_n),
  .drive            (drive)
);

// ==== test/i2c_master_model.sv ====
// Serial bus master model standing on the far side of the register bank
// Assumes the bench resolves SDA as open drain with a pull-up
`timescale 1ns/1ns
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Idle bus, both lines released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter bit, long enough for the slave's sync path
  task automatic tick();
    repeat (10) @(posedge clk);
  endtask

  task automatic put_bit(input logic b, output logic s);
    tick();
    sda_low <= ~b;
    tick();
    scl <= 1'b1;
    tick();
    s = sda;
    tick();
    scl <= 1'b0;
  endtask

  task automatic start();
    tick();
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], s);
      rx[i] = s;
    end
    put_bit(mack, ack);
  endtask
endmodule // i2c_master_model

// ==== test/flash_driver_mode_control_test.sv ====
// Self-checking bench for the flash driver mode control block
// Assumes the master model on the serial pins and the bound checker
`timescale 1ns/1ns
module flash_driver_mode_control_test;
  import flash_ctrl_pkg::*;
  localparam int unsigned STEP = 20;
  logic       clk;
  logic       rst;
  logic       link_clk;
  logic       strobe;
  logic       cap;
  logic       scl;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe_n;
  logic       eoc_n;
  drive_s     drive;
  logic [7:0] rv;
  logic       ack;
  int         n;
  int         bad_count = 0;
  int         cmp_count = 0;
  logic [7:0] ra [5] = '{8'h10, 8'ha0, 8'hb0, 8'hc0, 8'hd0};
  logic [7:0] r0 [5] = '{8'h00, 8'hf8, 8'h80, 8'hf9, 8'hc6};
  // Open-drain line with pull-up
  wire        sda = (sda_oe_n | sda_out) & ~sda_low;

  flash_driver_mode_control #(.STEP_CYCLES(STEP)) dut (
    .clk              (clk),
    .rst              (rst),
    .link_clk         (link_clk),
    .scl_in           (scl),
    .sda_in           (sda),
    .strobe_in        (strobe),
    .cap_at_target_in (cap),
    .sda_out          (sda_out),
    .sda_oe_n         (sda_oe_n),
    .eoc_n            (eoc_n),
    .drive            (drive)
  );
  i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // Core clock and an unrelated link clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1;
    forever #3 link_clk = ~link_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address, register byte, data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] b [3];
    logic [7:0] x;
    logic       k;
    b = '{{7'h53, 1'b0}, a, d};
    m.start();
    foreach (b[i]) begin
      m.xfer(b[i], 1'b1, x, k);
      chk(k, 1'b0);
    end
    m.stop();
  endtask

  // Pointer write, repeated start, one byte read with a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    logic       k;
    m.start();
    m.xfer({7'h53, 1'b0}, 1'b1, x, k);
    m.xfer(a, 1'b1, x, k);
    m.start();
    m.xfer({7'h53, 1'b1}, 1'b1, x, k);
    chk(k, 1'b0);
    m.xfer(8'hff, 1'b1, d, k);
    m.stop();
  endtask

  // Flash length in core cycles, zero when none starts
  task automatic flash_len(output int len);
    int w;
    len = 0;
    w = 0;
    // Looked at on the falling edge, where the output has settled
    while (drive.flash_en !== 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    while (drive.flash_en === 1'b1 && len < 2000) begin
      @(negedge clk);
      len++;
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    rst    = 1'b1;
    strobe = 1'b0;
    cap    = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(eoc_n, 1'b1);
    chk(drive.flash_level, 3'h7);
    chk({drive.active, drive.torch_en, drive.flash_en}, 3'h0);
    chk({drive.sense_hi, drive.sense_lo}, 16'hf9c6);
    foreach (ra[i]) begin
      rd(ra[i], rv);
      chk(rv, r0[i]);
    end
    $display("test power-on done");
    m.start();
    m.xfer({7'h54, 1'b0}, 1'b1, rv, ack);
    m.stop();
    chk(ack, 1'b1);
    wr(8'h20, 8'h5a);
    rd(8'h20, rv);
    chk(rv, 8'h00);
    $display("test addressing done");
    cap <= 1'b1;
    wr(8'ha0, 8'h18);
    wr(8'h10, 8'h8a);
    repeat (8) @(posedge clk);
    chk(eoc_n, 1'b0);
    chk(drive.indicator_en, 1'b1);
    chk(drive.charge_target, 2'h1);
    chk(drive.flash_level, 3'h3);
    chk({drive.charge_en, drive.torch_en}, 2'b10);
    wr(8'h10, 8'h03);
    repeat (8) @(posedge clk);
    chk(eoc_n, 1'b0);
    chk({drive.charge_en, drive.torch_en}, 2'b11);
    wr(8'h10, 8'h01);
    repeat (8) @(posedge clk);
    chk(eoc_n, 1'b1);
    chk({drive.charge_en, drive.torch_en}, 2'b01);
    $display("test modes done");
    cap <= 1'b0;
    wr(8'hb0, 8'h08);
    wr(8'h10, 8'h02);
    wr(8'h10, 8'h06);
    repeat (50) @(posedge clk);
    chk(drive.flash_en, 1'b0);
    cap <= 1'b1;
    flash_len(n);
    chk(n, 2 * STEP);
    rd(8'h10, rv);
    chk(rv, 8'h00);
    cap <= 1'b0;
    wr(8'hb0, 8'h78);
    fork
      wr(8'h10, 8'h2f);
      flash_len(n);
    join
    chk(n, 32 * STEP);
    rd(8'h10, rv);
    chk(rv, 8'h2a);
    $display("test software flash done");
    wr(8'hb0, 8'h88);
    wr(8'h10, 8'h20);
    fork
      flash_len(n);
      begin
        strobe <= 1'b1;
        repeat (15) @(posedge clk);
        strobe <= 1'b0;
      end
    join
    chk(n > 0 && n < 2 * STEP, 1'b1);
    wr(8'hb0, 8'h08);
    fork
      flash_len(n);
      begin
        strobe <= 1'b1;
        repeat (3) @(posedge clk);
        strobe <= 1'b0;
      end
    join
    chk(n, 2 * STEP);
    rd(8'h10, rv);
    chk(rv, 8'h20);
    $display("test strobe done");
    stop_test();
  end
endmodule // flash_driver_mode_control_test
